//--- hw/lpmc_map.vh
// register map, field positions, reset values and state codes of the power-mode controller
// Operation
// - light sleep stops only the core clock
// - leaving light sleep just restarts core clock
// - light sleep holds until reset or interrupt
// - peripherals run; their interrupts wake core
// - deep sleep stops peripheral clocks, non-RC sources
// - RC output off unless it clocks watchdog
// - deep sleep: analog off, flash standby
// - deep sleep may keep watchdog osc, brownout
// - deep sleep wakes on reset, pins, watchdog
// - power-down: all off except kept watchdog osc
// - power-down: analog, flash off; brownout optional
// - power-down wakes on reset, pins, watchdog
// - deepest state: all off, wake pin only
// - lock bit refuses deepest power-off entry
// - reset pin ignored in deepest state
// - after reset system clock is RC oscillator
`ifndef LPMC_MAP_VH
`define LPMC_MAP_VH

// byte offsets of the register words
`define LPMC_OFS_CFG      4'h0
`define LPMC_OFS_STATUS   4'h4
`define LPMC_OFS_WAKEMASK 4'h8
`define LPMC_OFS_CLKSEL   4'hc

// configuration word fields
`define LPMC_CFG_WDOSC_KEEP 0
`define LPMC_CFG_BOD_KEEP   1
`define LPMC_CFG_IRC_WDT    2
`define LPMC_CFG_DPD_LOCK   3
`define LPMC_CFG_SYSOSC_EN  4
`define LPMC_CFG_W          5
`define LPMC_CFG_RST        5'h00

// status word fields
`define LPMC_ST_STATE_LSB   0
`define LPMC_ST_DPD_WAKE    8
`define LPMC_ST_LOCK_HIT    9

// mode select codes on the request port
`define LPMC_MODE_SLEEP     2'h0
`define LPMC_MODE_DSLEEP    2'h1
`define LPMC_MODE_PDOWN     2'h2
`define LPMC_MODE_DPD       2'h3

// controller states
`define LPMC_S_RUN          3'h0
`define LPMC_S_SLEEP        3'h1
`define LPMC_S_DSLEEP       3'h2
`define LPMC_S_PDOWN        3'h3
`define LPMC_S_DPD          3'h4

// system clock source codes
`define LPMC_CLK_IRC        2'h0
`define LPMC_CLK_RST        2'h0

`endif

//--- hw/lpmc_wake.v
// wake event detector for the selected general-purpose pins
`timescale 1ns/100ps
`include "lpmc_map.vh"
module lpmc_wake #(
	parameter N_PINS = 8
) (
	input  wire              clk_i,     // system clock
	input  wire              reset_n_i, // async reset, active low
	input  wire [N_PINS-1:0] gpio_i,    // pin levels, synchronous
	input  wire [N_PINS-1:0] mask_i,    // pin selected for wake
	output wire              event_o    // any selected pin rose
);
	reg  [N_PINS-1:0] prev_q; // last sampled pin levels
	wire [N_PINS-1:0] rise;   // per-pin rising edge

	// one edge detector per pin
	genvar g;
	generate
		for (g = 0; g < N_PINS; g = g + 1)
		begin : g_pin
			always @(posedge clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
					prev_q[g] <= 1'b0;
				else
					prev_q[g] <= gpio_i[g];
			end
			assign rise[g] = gpio_i[g] & ~prev_q[g] & mask_i[g];
		end
	endgenerate

	// edges, not levels, so a pin parked high cannot re-wake at once
	assign event_o = |rise;
endmodule // lpmc_wake

//--- hw/lpmc_clksel.v
// system clock source selection, forced back to the rc oscillator on every reset
`timescale 1ns/100ps
`include "lpmc_map.vh"
module lpmc_clksel (
	input  wire       clk_i,     // system clock
	input  wire       reset_n_i, // async reset, active low
	input  wire       force_i,   // chip reset event, back to rc
	input  wire       wr_i,      // software selects a source
	input  wire [1:0] sel_i,     // requested source code
	output reg  [1:0] sel_o      // active source code
);
	// reset and reset events win over a software write
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			sel_o <= `LPMC_CLK_RST;
		else if (force_i)
			sel_o <= `LPMC_CLK_IRC;
		else if (wr_i)
			sel_o <= sel_i;
	end
endmodule // lpmc_clksel

//--- hw/lpmc_ctrl.v
// low-power mode controller: state sequencing, clock and power gating, register port
`timescale 1ns/100ps
`include "lpmc_map.vh"
module lpmc_ctrl #(
	parameter N_PINS = 8
) (
	input  wire              clk_i,            // system clock, 10 mhz
	input  wire              reset_n_i,        // async reset, active low
	input  wire [3:0]        reg_addr_i,       // register byte address
	input  wire [31:0]       reg_wdata_i,      // register write data
	input  wire              reg_wr_i,         // write strobe
	input  wire              reg_rd_i,         // read strobe
	output reg  [31:0]       reg_rdata_o,      // read data, cycle after strobe
	input  wire              sleep_req_i,      // low-power request strobe
	input  wire [1:0]        mode_i,           // requested low-power mode
	input  wire              irq_i,            // any peripheral interrupt
	input  wire              wdt_irq_i,        // watchdog interrupt
	input  wire [N_PINS-1:0] gpio_i,           // general-purpose pin levels
	input  wire              wake_pin_n_i,     // wake pin, low wakes
	input  wire              rst_pin_n_i,      // external reset pin, low
	output reg               core_clk_en_o,    // processor core clock on
	output reg               periph_clk_en_o,  // peripheral clocks on
	output reg               irc_en_o,         // rc oscillator output on
	output reg               sysosc_en_o,      // system oscillator on
	output reg               wdt_osc_en_o,     // watchdog oscillator on
	output reg               bod_en_o,         // brownout detector on
	output reg               analog_en_o,      // analog blocks powered
	output reg               flash_on_o,       // flash fully powered
	output reg               flash_standby_o,  // flash in standby
	output reg               chip_pwr_en_o,    // main chip power on
	output reg               chip_reset_o,     // chip reset pulse
	output reg  [1:0]        sysclk_sel_o,     // system clock source
	output reg  [2:0]        state_o           // current power state
);
	// control and status registers
	reg  [`LPMC_CFG_W-1:0] cfg_q;      // configuration word
	reg  [N_PINS-1:0]      wmask_q;    // wake pin selection
	reg                    dpd_wake_q; // woke from deepest state
	reg                    lock_hit_q; // locked deepest request seen
	reg  [2:0]             state_q;    // power state
	reg  [2:0]             state_d;    // next power state
	reg                    rst_pin_q;  // reset pin level last cycle

	// decoded register accesses
	wire wr_cfg  = reg_wr_i & (reg_addr_i == `LPMC_OFS_CFG);
	wire wr_st   = reg_wr_i & (reg_addr_i == `LPMC_OFS_STATUS);
	wire wr_msk  = reg_wr_i & (reg_addr_i == `LPMC_OFS_WAKEMASK);
	wire wr_clk  = reg_wr_i & (reg_addr_i == `LPMC_OFS_CLKSEL);

	// configuration bits by name
	wire wdosc_keep = cfg_q[`LPMC_CFG_WDOSC_KEEP];
	wire bod_keep   = cfg_q[`LPMC_CFG_BOD_KEEP];
	wire irc_wdt    = cfg_q[`LPMC_CFG_IRC_WDT];
	wire dpd_lock   = cfg_q[`LPMC_CFG_DPD_LOCK];
	wire sysosc_cfg = cfg_q[`LPMC_CFG_SYSOSC_EN];

	// wake sources
	wire gpio_evt;                                  // selected pin edge
	wire rst_evt  = ~rst_pin_n_i & rst_pin_q;       // reset pin falling
	wire in_dpd   = (state_q == `LPMC_S_DPD);
	wire pin_rst  = rst_evt & ~in_dpd;
	wire dpd_wake = in_dpd & ~wake_pin_n_i;
	wire deep_wk  = pin_rst | gpio_evt | wdt_irq_i;
	wire lock_req = sleep_req_i & (mode_i == `LPMC_MODE_DPD) & dpd_lock;
	wire reset_ev = pin_rst | dpd_wake;             // a chip reset occurs

	lpmc_wake #(
		.N_PINS    (N_PINS)
	) u_wake (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.gpio_i    (gpio_i),
		.mask_i    (wmask_q),
		.event_o   (gpio_evt)
	);

	wire [1:0] clk_sel; // active clock source
	lpmc_clksel u_clksel (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.force_i   (reset_ev),
		.wr_i      (wr_clk),
		.sel_i     (reg_wdata_i[1:0]),
		.sel_o     (clk_sel)
	);

	// next-state logic for the power sequencer
	always @*
	begin
		state_d = state_q;
		case (state_q)
			`LPMC_S_RUN:
			begin
				// a request strobe selects the target state
				if (sleep_req_i)
				begin
					case (mode_i)
						`LPMC_MODE_SLEEP:  state_d = `LPMC_S_SLEEP;
						`LPMC_MODE_DSLEEP: state_d = `LPMC_S_DSLEEP;
						`LPMC_MODE_PDOWN:  state_d = `LPMC_S_PDOWN;
						`LPMC_MODE_DPD:
						begin
							// locked: fall back to light sleep
							if (dpd_lock)
								state_d = `LPMC_S_SLEEP;
							else
								state_d = `LPMC_S_DPD;
						end
						default:           state_d = `LPMC_S_RUN;
					endcase
				end
			end
			`LPMC_S_SLEEP:
			begin
				// any interrupt or reset resumes execution
				if (irq_i | wdt_irq_i | gpio_evt | pin_rst)
					state_d = `LPMC_S_RUN;
			end
			`LPMC_S_DSLEEP:
			begin
				if (deep_wk)
					state_d = `LPMC_S_RUN;
			end
			`LPMC_S_PDOWN:
			begin
				if (deep_wk)
					state_d = `LPMC_S_RUN;
			end
			`LPMC_S_DPD:
			begin
				// only the wake pin leaves; reset pin is dead here
				if (dpd_wake)
					state_d = `LPMC_S_RUN;
			end
			default:
				state_d = `LPMC_S_RUN;
		endcase
	end

	// state register and reset pin history
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q   <= `LPMC_S_RUN;
			rst_pin_q <= 1'b1;
		end
		else
		begin
			state_q   <= state_d;
			rst_pin_q <= rst_pin_n_i;
		end
	end

	// gating outputs, registered from the next state so they switch
	// in the same edge as the state itself
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			core_clk_en_o   <= 1'b1;
			periph_clk_en_o <= 1'b1;
			irc_en_o        <= 1'b1;
			sysosc_en_o     <= 1'b0;
			wdt_osc_en_o    <= 1'b0;
			bod_en_o        <= 1'b1;
			analog_en_o     <= 1'b1;
			flash_on_o      <= 1'b1;
			flash_standby_o <= 1'b0;
			chip_pwr_en_o   <= 1'b1;
		end
		else
		begin
			case (state_d)
				`LPMC_S_SLEEP:
				begin
					// only the core stops; peripherals keep running
					core_clk_en_o   <= 1'b0;
					periph_clk_en_o <= 1'b1;
					irc_en_o        <= 1'b1;
					sysosc_en_o     <= sysosc_cfg;
					wdt_osc_en_o    <= wdosc_keep;
					bod_en_o        <= 1'b1;
					analog_en_o     <= 1'b1;
					flash_on_o      <= 1'b1;
					flash_standby_o <= 1'b0;
					chip_pwr_en_o   <= 1'b1;
				end
				`LPMC_S_DSLEEP:
				begin
					core_clk_en_o   <= 1'b0;
					periph_clk_en_o <= 1'b0;
					irc_en_o        <= irc_wdt;
					sysosc_en_o     <= 1'b0;
					wdt_osc_en_o    <= wdosc_keep;
					bod_en_o        <= bod_keep;
					analog_en_o     <= 1'b0;
					flash_on_o      <= 1'b0;
					flash_standby_o <= 1'b1;
					chip_pwr_en_o   <= 1'b1;
				end
				`LPMC_S_PDOWN:
				begin
					core_clk_en_o   <= 1'b0;
					periph_clk_en_o <= 1'b0;
					irc_en_o        <= 1'b0;
					sysosc_en_o     <= 1'b0;
					wdt_osc_en_o    <= wdosc_keep;
					bod_en_o        <= bod_keep;
					analog_en_o     <= 1'b0;
					flash_on_o      <= 1'b0;
					flash_standby_o <= 1'b0;
					chip_pwr_en_o   <= 1'b1;
				end
				`LPMC_S_DPD:
				begin
					// everything off; the wake pin logic stays alive
					core_clk_en_o   <= 1'b0;
					periph_clk_en_o <= 1'b0;
					irc_en_o        <= 1'b0;
					sysosc_en_o     <= 1'b0;
					wdt_osc_en_o    <= 1'b0;
					bod_en_o        <= 1'b0;
					analog_en_o     <= 1'b0;
					flash_on_o      <= 1'b0;
					flash_standby_o <= 1'b0;
					chip_pwr_en_o   <= 1'b0;
				end
				default:
				begin
					// run: core and peripheral clocks, rc, brownout, analog and flash back on; system and watchdog osc per config
					core_clk_en_o   <= 1'b1;
					periph_clk_en_o <= 1'b1;
					irc_en_o        <= 1'b1;
					sysosc_en_o     <= sysosc_cfg;
					wdt_osc_en_o    <= wdosc_keep;
					bod_en_o        <= 1'b1;
					analog_en_o     <= 1'b1;
					flash_on_o      <= 1'b1;
					flash_standby_o <= 1'b0;
					chip_pwr_en_o   <= 1'b1;
				end
			endcase
		end
	end

	// chip reset pulse, state and clock source mirrors
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			chip_reset_o <= 1'b0;
			state_o      <= `LPMC_S_RUN;
			sysclk_sel_o <= `LPMC_CLK_RST;
		end
		else
		begin
			chip_reset_o <= reset_ev;
			state_o      <= state_d;
			// one cycle behind the selector; on a reset event go to rc now
			sysclk_sel_o <= reset_ev ? `LPMC_CLK_IRC : clk_sel;
		end
	end

	// software-written registers
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cfg_q   <= `LPMC_CFG_RST;
			wmask_q <= {N_PINS{1'b0}};
		end
		else
		begin
			if (wr_cfg)
				cfg_q <= reg_wdata_i[`LPMC_CFG_W-1:0];
			if (wr_msk)
				wmask_q <= reg_wdata_i[N_PINS-1:0];
		end
	end

	// sticky status flags: write one clears, a new event wins
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dpd_wake_q <= 1'b0;
			lock_hit_q <= 1'b0;
		end
		else
		begin
			if (dpd_wake)
				dpd_wake_q <= 1'b1;
			else if (wr_st & reg_wdata_i[`LPMC_ST_DPD_WAKE])
				dpd_wake_q <= 1'b0;
			if (lock_req & (state_q == `LPMC_S_RUN))
				lock_hit_q <= 1'b1;
			else if (wr_st & reg_wdata_i[`LPMC_ST_LOCK_HIT])
				lock_hit_q <= 1'b0;
		end
	end

	// read port: data only in the cycle after the strobe, zero elsewhere
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			reg_rdata_o <= 32'h00000000;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`LPMC_OFS_CFG:
					reg_rdata_o <= {{(32-`LPMC_CFG_W){1'b0}}, cfg_q};
				`LPMC_OFS_STATUS:
					reg_rdata_o <= {22'h0, lock_hit_q, dpd_wake_q, 5'h00, state_q};
				`LPMC_OFS_WAKEMASK:
					reg_rdata_o <= {{(32-N_PINS){1'b0}}, wmask_q};
				`LPMC_OFS_CLKSEL:
					reg_rdata_o <= {30'h0, clk_sel};
				default:
					reg_rdata_o <= 32'h00000000; // unmapped reads zero
			endcase
		end
		else
			reg_rdata_o <= 32'h00000000;
	end
endmodule // lpmc_ctrl

//--- sim/lpmc_properties.sv
// port-level assertions of the power-mode controller
`timescale 1ns/100ps
module lpmc_properties (
	input logic        clk_i,           // system clock
	input logic        reset_n_i,       // async reset
	input logic [3:0]  reg_addr_i,      // register address
	input logic [31:0] reg_wdata_i,     // write data
	input logic        reg_wr_i,        // write strobe
	input logic        sleep_req_i,     // mode request
	input logic [1:0]  mode_i,          // requested mode
	input logic        irq_i,           // peripheral interrupt
	input logic        wdt_irq_i,       // watchdog interrupt
	input logic        wake_pin_n_i,    // wake pin
	input logic        core_clk_en_o,   // core clock
	input logic        periph_clk_en_o, // peripheral clocks
	input logic        irc_en_o,        // rc output
	input logic        sysosc_en_o,     // system oscillator
	input logic        wdt_osc_en_o,    // watchdog oscillator
	input logic        bod_en_o,        // brownout detector
	input logic        analog_en_o,     // analog power
	input logic        flash_on_o,      // flash powered
	input logic        flash_standby_o, // flash standby
	input logic        chip_pwr_en_o,   // chip power
	input logic        chip_reset_o,    // reset pulse
	input logic [1:0]  sysclk_sel_o,    // clock source
	input logic [2:0]  state_o          // power state
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [4:0] cfg_q; // shadow of the config word
	// shadow follows software writes; a chip reset event is not mirrored
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			cfg_q <= 5'h00;
		else if (reg_wr_i && reg_addr_i == 4'h0)
			cfg_q <= reg_wdata_i[4:0];
	end
	a_sleep_core_off: assert property (sleep_req_i && state_o == 3'h0 && mode_i == 2'h0
		|=> state_o == 3'h1 && !core_clk_en_o && periph_clk_en_o) else $error("sleep entry");
	a_sleep_wake_irq: assert property (state_o == 3'h1 && (irq_i || wdt_irq_i)
		|=> state_o == 3'h0 && core_clk_en_o) else $error("sleep wake");
	a_dsleep_gate_off: assert property (state_o == 3'h2
		|-> !core_clk_en_o && !periph_clk_en_o && !sysosc_en_o && !analog_en_o && !flash_on_o
		&& flash_standby_o) else $error("dsleep gating");
	a_dsleep_cfg_keep: assert property (state_o == 3'h2 |-> irc_en_o == cfg_q[2]
		&& wdt_osc_en_o == cfg_q[0] && bod_en_o == cfg_q[1]) else $error("dsleep keep");
	a_pdown_gate_off: assert property (state_o == 3'h3
		|-> !irc_en_o && !periph_clk_en_o && !sysosc_en_o && !analog_en_o && !flash_on_o
		&& !flash_standby_o && wdt_osc_en_o == cfg_q[0] && bod_en_o == cfg_q[1])
		else $error("pdown gating");
	a_deep_wdt_wake: assert property ((state_o == 3'h2 || state_o == 3'h3)
		&& wdt_irq_i |=> state_o == 3'h0) else $error("deep wake");
	a_dpd_all_off: assert property (state_o == 3'h4 |-> !chip_pwr_en_o && !core_clk_en_o
		&& !irc_en_o && !bod_en_o && !wdt_osc_en_o) else $error("dpd power");
	a_dpd_pin_hold: assert property (state_o == 3'h4 && wake_pin_n_i
		|=> state_o == 3'h4 && !chip_reset_o) else $error("dpd hold");
	a_dpd_pin_wake: assert property (state_o == 3'h4 && !wake_pin_n_i
		|=> state_o == 3'h0 ##[0:1] chip_reset_o) else $error("dpd wake");
	a_lock_to_sleep: assert property (sleep_req_i && state_o == 3'h0
		&& mode_i == 2'h3 && cfg_q[3] |=> state_o == 3'h1 && chip_pwr_en_o)
		else $error("lock refuse");
	a_reset_clk_rc: assert property ($rose(chip_reset_o) |-> ##[0:2] sysclk_sel_o == 2'h0)
		else $error("clock after reset");
endmodule // lpmc_properties

bind lpmc_ctrl lpmc_properties u_lpmc_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.sleep_req_i(sleep_req_i), .mode_i(mode_i), .irq_i(irq_i), .wdt_irq_i(wdt_irq_i),
	.wake_pin_n_i(wake_pin_n_i), .core_clk_en_o(core_clk_en_o),
	.periph_clk_en_o(periph_clk_en_o), .irc_en_o(irc_en_o), .sysosc_en_o(sysosc_en_o),
	.wdt_osc_en_o(wdt_osc_en_o), .bod_en_o(bod_en_o), .analog_en_o(analog_en_o),
	.flash_on_o(flash_on_o), .flash_standby_o(flash_standby_o),
	.chip_pwr_en_o(chip_pwr_en_o), .chip_reset_o(chip_reset_o),
	.sysclk_sel_o(sysclk_sel_o), .state_o(state_o));

//--- sim/lpmc_core_model.sv
// processor-side model: mode requests and interrupt pulses
`timescale 1ns/100ps
module lpmc_core_model (
	input  logic       clk_i,       // system clock
	output logic       sleep_req_o, // mode request strobe
	output logic [1:0] mode_o,      // requested mode
	output logic       irq_o,       // peripheral interrupt
	output logic       wdt_irq_o    // watchdog interrupt
);
	// idle values from time zero
	initial
	begin
		sleep_req_o = 1'b0;
		mode_o = 2'h0;
		irq_o = 1'b0;
		wdt_irq_o = 1'b0;
	end
	// one-cycle strobe, mode held beside it until after the edge
	task request(input logic [1:0] m);
	begin
		@(posedge clk_i);
		sleep_req_o <= 1'b1;
		mode_o <= m;
		@(posedge clk_i);
		sleep_req_o <= 1'b0;
	end
	endtask
	// one-cycle interrupt, watchdog or peripheral
	task interrupt(input logic wdt);
	begin
		@(posedge clk_i);
		if (wdt)
			wdt_irq_o <= 1'b1;
		else
			irq_o <= 1'b1;
		@(posedge clk_i);
		wdt_irq_o <= 1'b0;
		irq_o <= 1'b0;
	end
	endtask
endmodule // lpmc_core_model

//--- sim/tb_top.sv
// directed testbench of the power-mode controller
`timescale 1ns/100ps
module tb_top;
	logic        clk_i;               // 10 mhz clock
	logic        reset_n_i;           // block reset
	logic [3:0]  reg_addr_i;          // register address
	logic [31:0] reg_wdata_i;         // write data
	logic        reg_wr_i;            // write strobe
	logic        reg_rd_i;            // read strobe
	logic [7:0]  gpio_i;              // pin levels
	logic        wake_pin_n_i;        // held high by pull-up
	logic        rst_pin_n_i;         // reset pin idle
	wire  [31:0] reg_rdata_o;         // read data
	wire  [1:0]  mode_i, sysclk_sel_o;
	wire  [2:0]  state_o;
	wire         sleep_req_i, irq_i, wdt_irq_i, core_clk_en_o, periph_clk_en_o, irc_en_o;
	wire         sysosc_en_o, wdt_osc_en_o, bod_en_o, analog_en_o, flash_on_o;
	wire         flash_standby_o, chip_pwr_en_o, chip_reset_o;
	wire  [9:0]  outs = {core_clk_en_o, periph_clk_en_o, irc_en_o, sysosc_en_o, wdt_osc_en_o,
		bod_en_o, analog_en_o, flash_on_o, flash_standby_o, chip_pwr_en_o}; // gating view
	int n_errors = 0;   // mismatches
	int num_checks = 0; // comparisons
	always #50 clk_i = ~clk_i;
	lpmc_core_model i_lpmc_core_model (.clk_i(clk_i), .sleep_req_o(sleep_req_i),
		.mode_o(mode_i), .irq_o(irq_i), .wdt_irq_o(wdt_irq_i));
	lpmc_ctrl #(.N_PINS(8)) i_lpmc_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sleep_req_i(sleep_req_i),
		.mode_i(mode_i), .irq_i(irq_i), .wdt_irq_i(wdt_irq_i), .gpio_i(gpio_i),
		.wake_pin_n_i(wake_pin_n_i), .rst_pin_n_i(rst_pin_n_i), .core_clk_en_o(core_clk_en_o),
		.periph_clk_en_o(periph_clk_en_o), .irc_en_o(irc_en_o), .sysosc_en_o(sysosc_en_o),
		.wdt_osc_en_o(wdt_osc_en_o), .bod_en_o(bod_en_o), .analog_en_o(analog_en_o),
		.flash_on_o(flash_on_o), .flash_standby_o(flash_standby_o),
		.chip_pwr_en_o(chip_pwr_en_o), .chip_reset_o(chip_reset_o),
		.sysclk_sel_o(sysclk_sel_o), .state_o(state_o));
	// compare and count
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
	begin
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	end
	endtask
	// state and gating outputs, sampled mid-cycle
	task chk_st(input logic [2:0] st, input logic [9:0] o);
	begin
		@(negedge clk_i);
		chk("state", {29'h0, st}, {29'h0, state_o});
		chk("gating", {22'h0, o}, {22'h0, outs});
	end
	endtask
	task reg_wr(input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	end
	endtask
	// data stand only in the cycle after the strobe
	task reg_rd(input logic [3:0] a, input logic [31:0] exp);
	begin
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		chk("rdata", exp, reg_rdata_o);
	end
	endtask
	// bounded wait for the return to run
	task wait_run;
	begin
		for (int k = 0; k < 8 && state_o !== 3'h0; k++)
			@(negedge clk_i);
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// hang guard, far beyond the ninety-odd cycles needed
	initial
	begin
		#400000;
		n_errors++;
		give_verdict();
	end
	initial
	begin
		clk_i = 1'b0;
		reset_n_i = 1'b0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		gpio_i = 8'h00;
		wake_pin_n_i = 1'b1;
		rst_pin_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk_st(3'h0, 10'h39d);
		chk("clock", 32'h0, {30'h0, sysclk_sel_o});
		reg_rd(4'h2, 32'h0);
		i_lpmc_core_model.request(2'h0);
		chk_st(3'h1, 10'h19d);
		repeat (3) @(posedge clk_i);
		chk_st(3'h1, 10'h19d);
		i_lpmc_core_model.interrupt(1'b0);
		chk_st(3'h0, 10'h39d);
		// deep sleep keeping rc, watchdog osc and brownout
		reg_wr(4'h0, 32'h7);
		i_lpmc_core_model.request(2'h1);
		chk_st(3'h2, 10'h0b3);
		i_lpmc_core_model.interrupt(1'b0);
		chk_st(3'h2, 10'h0b3);
		i_lpmc_core_model.interrupt(1'b1);
		chk_st(3'h0, 10'h3bd);
		// deep sleep, nothing kept; only pin 0 may wake
		reg_wr(4'h0, 32'h0);
		reg_wr(4'h8, 32'h1);
		i_lpmc_core_model.request(2'h1);
		chk_st(3'h2, 10'h003);
		@(posedge clk_i);
		gpio_i <= 8'h02;
		repeat (4) @(posedge clk_i);
		chk_st(3'h2, 10'h003);
		@(posedge clk_i);
		gpio_i <= 8'h03;
		wait_run();
		chk_st(3'h0, 10'h39d);
		@(posedge clk_i);
		gpio_i <= 8'h00;
		// power-down keeping watchdog osc and brownout; system osc on in run
		reg_wr(4'h0, 32'h13);
		i_lpmc_core_model.request(2'h2);
		chk_st(3'h3, 10'h031);
		i_lpmc_core_model.interrupt(1'b1);
		chk_st(3'h0, 10'h3fd);
		// locked deepest request falls back to light sleep
		reg_wr(4'h0, 32'h8);
		i_lpmc_core_model.request(2'h3);
		chk_st(3'h1, 10'h19d);
		i_lpmc_core_model.interrupt(1'b0);
		reg_rd(4'h4, 32'h200);
		reg_wr(4'h4, 32'h200);
		reg_rd(4'h4, 32'h0);
		// software clock choice, undone by a reset pin event
		reg_wr(4'hc, 32'h2);
		reg_rd(4'hc, 32'h2);
		chk("clock", 32'h2, {30'h0, sysclk_sel_o});
		@(posedge clk_i);
		rst_pin_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_pin_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("clock", 32'h0, {30'h0, sysclk_sel_o});
		// deepest state: reset pin and watchdog interrupt ignored
		reg_wr(4'h0, 32'h0);
		i_lpmc_core_model.request(2'h3);
		chk_st(3'h4, 10'h000);
		@(posedge clk_i);
		rst_pin_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_pin_n_i <= 1'b1;
		i_lpmc_core_model.interrupt(1'b1);
		chk_st(3'h4, 10'h000);
		@(posedge clk_i);
		wake_pin_n_i <= 1'b0;
		wait_run();
		@(posedge clk_i);
		wake_pin_n_i <= 1'b1;
		chk_st(3'h0, 10'h39d);
		chk("clock", 32'h0, {30'h0, sysclk_sel_o});
		reg_rd(4'h4, 32'h100);
		reg_rd(4'h8, 32'h1);
		// block reset in mid-run undoes config and clock choice
		reg_wr(4'h0, 32'h1f);
		reg_wr(4'hc, 32'h3);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk_st(3'h0, 10'h39d);
		chk("clock", 32'h0, {30'h0, sysclk_sel_o});
		reg_rd(4'h0, 32'h0);
		give_verdict();
	end
endmodule // tb_top
